// *** hw/tws_params.svh ***
// constants of the two-wire bus switch control block
// included by the stuck timer, the switch control and the bench, not by the package or the synchroniser; definitions only
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// register offsets on the upstream two-wire bus
`define TWS_OFS_FAULT 8'h00
`define TWS_OFS_POLICY 8'h02
`define TWS_OFS_SWITCH 8'h03

// connection_policy fields
`define TWS_POL_FORCE_BIT 5
`define TWS_POL_MW_BIT 2
`define TWS_POL_TO_HI 1
`define TWS_POL_TO_LO 0
`define TWS_POL_FORCE_RST 1'h0
`define TWS_POL_MW_RST 1'h1
`define TWS_POL_TO_RST 2'h0

// branch_switch_state fields
`define TWS_SW_B1_BIT 7
`define TWS_SW_B2_BIT 6
`define TWS_SW_L1_BIT 3
`define TWS_SW_L2_BIT 2
`define TWS_SW_RST 1'h0

// timeout select codes
`define TWS_TO_OFF 2'h0
`define TWS_TO_LONG 2'h1
`define TWS_TO_MID 2'h2
`define TWS_TO_SHORT 2'h3

// two-wire addresses; device address value is arbitrary
`define TWS_DEV_ADDR 7'h4A
`define TWS_MASS_ADDR 7'h5E

// timing: system clock rate and stuck-low times in microseconds
`define TWS_CLK_MHZ 200
`define TWS_TO_LONG_US 30000
`define TWS_TO_MID_US 15000
`define TWS_TO_SHORT_US 7500

`endif

// *** hw/tws_pkg.sv ***
// types shared by the two-wire bus switch control files
// no assumptions beyond the params header
`default_nettype none
package tws_pkg;
  typedef struct packed {
    logic force_conn;
    logic mass_wr_en;
    logic [1:0] to_sel;
  } tws_pol_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tws_req_t;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_ADDR,
    LS_AACK,
    LS_BYTE,
    LS_WACK,
    LS_RLOAD,
    LS_RBIT,
    LS_RACK
  } tws_lnk_st_t;
endpackage
`default_nettype wire

// *** hw/tws_stuck_timer.sv ***
// stuck-low watchdog counter with selectable limit
// i_run and i_sel are synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"
module tws_stuck_timer #(
  parameter int unsigned LONG_CYC = 1,
  parameter int unsigned MID_CYC = 1,
  parameter int unsigned SHORT_CYC = 1
) (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_run, // a common node is low
  input wire logic [1:0] i_sel, // timeout select code
  output logic o_hit // limit reached, level
);
  localparam int CW = $clog2(LONG_CYC + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] lim;

  function automatic logic [CW-1:0] limit_of(input logic [1:0] sel);
    case (sel)
      `TWS_TO_LONG: limit_of = CW'(LONG_CYC);
      `TWS_TO_MID: limit_of = CW'(MID_CYC);
      default: limit_of = CW'(SHORT_CYC);
    endcase
  endfunction

  assign lim = limit_of(i_sel);
  assign o_hit = (i_sel != `TWS_TO_OFF) && (cnt_reg == lim);

  // run while low, clear when high
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_reg <= '0;
    else if (!i_run || i_sel == `TWS_TO_OFF)
      cnt_reg <= '0;
    else if (cnt_reg < lim)
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule
`default_nettype wire

// *** hw/tws_switch_ctrl.sv ***
// two-wire bus switch control: registers, connection, faults, watchdog
// and the upstream two-wire slave. pins arrive as comparator levels;
// the slave oversamples the upstream lines on i_link_clk.
//
// Functional notes
// - default: connect only idle-high requested branches
// - force bit set: connect regardless of level
// - mass write address enable, default on
// - timeout select: off, 30, 15, 7.5 ms
// - switch bits set and report branch state
// - branch 1 idle bit: both lines high
// - branch 2 idle bit: both lines high
// - any branch combination may be connected
// - stuck low detaches upstream from downstream
// - supply bad: drivers released, traffic ignored
// - enable low: defaults held, commands ignored
// - branch faults forwarded even when disabled
// - enable high: reads and writes accepted
// - timer runs while common node low
// - timeout: fault low, isolate, switches kept
// - refused connection: fail flag, fault low
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"
module tws_switch_ctrl #(
  parameter int unsigned TO_LONG_CYC = `TWS_TO_LONG_US * `TWS_CLK_MHZ,
  parameter int unsigned TO_MID_CYC = `TWS_TO_MID_US * `TWS_CLK_MHZ,
  parameter int unsigned TO_SHORT_CYC = `TWS_TO_SHORT_US * `TWS_CLK_MHZ
) (
  input wire logic i_sys_clk, // system clock, 200 MHz
  input wire logic i_rstn, // async reset, active low
  input wire logic i_link_clk, // upstream oversampling clock
  input wire logic i_enable, // interface enable pin
  input wire logic i_supply_good, // supply above lockout
  input wire logic i_upstream_clock_line, // upstream clock level
  input wire logic i_upstream_data_line, // upstream data level
  input wire logic i_branch1_data_line, // branch 1 data above 1V
  input wire logic i_branch1_clock_line, // branch 1 clock above 1V
  input wire logic i_branch2_data_line, // branch 2 data above 1V
  input wire logic i_branch2_clock_line, // branch 2 clock above 1V
  input wire logic i_branch1_fault_in, // branch 1 fault, low active
  input wire logic i_branch2_fault_in, // branch 2 fault, low active
  input wire logic i_common_data_node, // common data node high
  input wire logic i_common_clock_node, // common clock node high
  output logic o_upstream_data_out, // upstream data drive value
  output var logic o_upstream_data_oe, // upstream data pulled low
  output logic o_upstream_clock_out, // upstream clock drive value
  output var logic o_upstream_clock_oe, // upstream clock stretched
  output var logic o_branch1_switch_bit, // branch 1 switch closed
  output var logic o_branch2_switch_bit, // branch 2 switch closed
  output var logic o_buffers_on, // up-down buffers biased
  output logic o_fault_out, // fault pin drive value
  output var logic o_fault_oe, // fault pin pulled low
  output var logic o_conn_fail_n, // low after refused connection
  output var logic o_timeout_latched // stuck-low timeout latched
);
  // ---------------- system domain ----------------
  logic [10:0] sys_raw;
  logic [10:0] sys_s;
  logic en_s, sup_s, b1_hi, b2_hi, f1_n, f2_n, node_low, req_s;
  logic active;
  logic req_new;
  logic wr_go;
  logic to_hit;
  logic zero_reg;
  logic acc_reg;
  logic ack_tgl_reg;
  logic [7:0] resp_reg;
  logic sw1_reg;
  logic sw2_reg;
  logic fail_n_reg;
  logic to_latch_reg;
  tws_pkg::tws_pol_t pol_reg;
  tws_pkg::tws_req_t req_word_reg;

  // link side state, declared here for the crossing
  logic req_tgl_reg;

  assign sys_raw = {i_enable, i_supply_good, i_branch1_data_line,
    i_branch1_clock_line, i_branch2_data_line, i_branch2_clock_line,
    i_branch1_fault_in, i_branch2_fault_in, i_common_data_node,
    i_common_clock_node, req_tgl_reg};

  tws_sync #(
    .W(11)
  ) u_sys_sync (
    .i_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_d(sys_raw),
    .o_q(sys_s)
  );

  assign en_s = sys_s[10];
  assign sup_s = sys_s[9];
  assign b1_hi = sys_s[8] & sys_s[7];
  assign b2_hi = sys_s[6] & sys_s[5];
  assign f1_n = sys_s[4];
  assign f2_n = sys_s[3];
  assign node_low = ~(sys_s[2] & sys_s[1]);
  assign req_s = sys_s[0];

  // access only when enabled and powered
  assign active = en_s & sup_s;
  assign req_new = req_s != ack_tgl_reg;
  assign wr_go = req_new & req_word_reg.wr & active;

  function automatic logic conn_ok(input logic req, input logic force_c,
    input logic hi, input logic cur);
    conn_ok = req & (force_c | hi | cur);
  endfunction

  function automatic logic conn_refused(input logic req, input logic force_c,
    input logic hi, input logic cur);
    conn_refused = req & ~force_c & ~hi & ~cur;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] addr,
    input tws_pkg::tws_pol_t pol, input logic s1, input logic s2,
    input logic h1, input logic h2);
    reg_read = 8'h00;
    case (addr)
      `TWS_OFS_POLICY:
      begin
        reg_read[`TWS_POL_FORCE_BIT] = pol.force_conn;
        reg_read[`TWS_POL_MW_BIT] = pol.mass_wr_en;
        reg_read[`TWS_POL_TO_HI:`TWS_POL_TO_LO] = pol.to_sel;
      end
      `TWS_OFS_SWITCH:
      begin
        reg_read[`TWS_SW_B1_BIT] = s1;
        reg_read[`TWS_SW_B2_BIT] = s2;
        reg_read[`TWS_SW_L1_BIT] = h1;
        reg_read[`TWS_SW_L2_BIT] = h2;
      end
      default: reg_read = 8'h00;
    endcase
  endfunction

  // request service: answer loaded into resp_reg on the same edge that ack toggles
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_tgl_reg <= 1'h0;
      resp_reg <= 8'h00;
    end
    else if (req_new)
    begin
      ack_tgl_reg <= req_s;
      resp_reg <= reg_read(req_word_reg.addr, pol_reg, sw1_reg, sw2_reg,
        b1_hi, b2_hi);
    end
  end

  // policy register
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pol_reg.force_conn <= `TWS_POL_FORCE_RST;
      pol_reg.mass_wr_en <= `TWS_POL_MW_RST;
      pol_reg.to_sel <= `TWS_POL_TO_RST;
    end
    else if (!active)
    begin
      pol_reg.force_conn <= `TWS_POL_FORCE_RST;
      pol_reg.mass_wr_en <= `TWS_POL_MW_RST;
      pol_reg.to_sel <= `TWS_POL_TO_RST;
    end
    else if (wr_go && req_word_reg.addr == `TWS_OFS_POLICY)
    begin
      pol_reg.force_conn <= req_word_reg.data[`TWS_POL_FORCE_BIT];
      pol_reg.mass_wr_en <= req_word_reg.data[`TWS_POL_MW_BIT];
      pol_reg.to_sel <= req_word_reg.data[`TWS_POL_TO_HI:`TWS_POL_TO_LO];
    end
  end

  // branch switches
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sw1_reg <= `TWS_SW_RST;
      sw2_reg <= `TWS_SW_RST;
    end
    else if (!active)
    begin
      sw1_reg <= `TWS_SW_RST;
      sw2_reg <= `TWS_SW_RST;
    end
    else if (wr_go && req_word_reg.addr == `TWS_OFS_SWITCH)
    begin
      sw1_reg <= conn_ok(req_word_reg.data[`TWS_SW_B1_BIT],
        pol_reg.force_conn, b1_hi, sw1_reg);
      sw2_reg <= conn_ok(req_word_reg.data[`TWS_SW_B2_BIT],
        pol_reg.force_conn, b2_hi, sw2_reg);
    end
  end

  // failed-connection flag; a write to offset 0 rearms it, set wins
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      fail_n_reg <= 1'h1;
    else if (!active)
      fail_n_reg <= 1'h1;
    else if (wr_go && req_word_reg.addr == `TWS_OFS_SWITCH &&
      (conn_refused(req_word_reg.data[`TWS_SW_B1_BIT], pol_reg.force_conn,
        b1_hi, sw1_reg) ||
       conn_refused(req_word_reg.data[`TWS_SW_B2_BIT], pol_reg.force_conn,
        b2_hi, sw2_reg)))
      fail_n_reg <= 1'h0;
    else if (wr_go && req_word_reg.addr == `TWS_OFS_FAULT)
      fail_n_reg <= 1'h1;
  end

  tws_stuck_timer #(
    .LONG_CYC(TO_LONG_CYC),
    .MID_CYC(TO_MID_CYC),
    .SHORT_CYC(TO_SHORT_CYC)
  ) u_timer (
    .i_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_run(active & node_low),
    .i_sel(pol_reg.to_sel),
    .o_hit(to_hit)
  );

  // latched timeout; set wins over the offset-0 clear
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      to_latch_reg <= 1'h0;
    else if (to_hit)
      to_latch_reg <= 1'h1;
    else if (!active || (wr_go && req_word_reg.addr == `TWS_OFS_FAULT))
      to_latch_reg <= 1'h0;
  end

  // pin outputs
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_fault_oe <= 1'h0;
      o_buffers_on <= 1'h0;
      o_branch1_switch_bit <= 1'h0;
      o_branch2_switch_bit <= 1'h0;
      o_conn_fail_n <= 1'h1;
      o_timeout_latched <= 1'h0;
      acc_reg <= 1'h0;
      zero_reg <= 1'h0;
    end
    else
    begin
      // fault pulled low, gated by supply
      o_fault_oe <= sup_s & (~f1_n | ~f2_n | to_latch_reg | ~fail_n_reg);
      o_buffers_on <= active & (sw1_reg | sw2_reg) & ~to_latch_reg;
      o_branch1_switch_bit <= sw1_reg;
      o_branch2_switch_bit <= sw2_reg;
      o_conn_fail_n <= fail_n_reg;
      o_timeout_latched <= to_latch_reg;
      acc_reg <= active;
      zero_reg <= 1'h0;
    end
  end

  // open-drain pins only ever drive low
  assign o_fault_out = zero_reg;
  assign o_upstream_data_out = zero_reg;
  assign o_upstream_clock_out = zero_reg;

  // ---------------- link domain ----------------
  logic [4:0] lnk_raw;
  logic [4:0] lnk_s;
  logic scl_s, sda_s, mw_s, acc_s, ack_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic rise, fall, start, stop;
  logic busy;
  logic hit_dev, hit_mass, hit;
  logic nack_reg;
  logic rd_reg;
  logic first_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shreg;
  logic [7:0] ptr_reg;
  tws_pkg::tws_lnk_st_t st_reg;

  assign lnk_raw = {i_upstream_clock_line, i_upstream_data_line,
    pol_reg.mass_wr_en, acc_reg, ack_tgl_reg};

  tws_sync #(
    .W(5)
  ) u_lnk_sync (
    .i_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_d(lnk_raw),
    .o_q(lnk_s)
  );

  assign scl_s = lnk_s[4];
  assign sda_s = lnk_s[3];
  assign mw_s = lnk_s[2];
  assign acc_s = lnk_s[1];
  assign ack_s = lnk_s[0];
  assign busy = req_tgl_reg != ack_s;

  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign rise = scl_s & ~scl_d_reg;
  assign fall = ~scl_s & scl_d_reg;
  assign start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  assign hit_dev = shreg[7:1] == `TWS_DEV_ADDR;
  assign hit_mass = (shreg[7:1] == `TWS_MASS_ADDR) & ~shreg[0] & mw_s;
  assign hit = hit_dev | hit_mass;

  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= tws_pkg::LS_IDLE;
      cnt_reg <= 4'h0;
      shreg <= 8'h00;
      ptr_reg <= 8'h00;
      rd_reg <= 1'h0;
      first_reg <= 1'h0;
      nack_reg <= 1'h0;
      o_upstream_data_oe <= 1'h0;
      req_tgl_reg <= 1'h0;
      req_word_reg <= '0;
    end
    // drop out and release when locked out
    else if (!acc_s || stop)
    begin
      st_reg <= tws_pkg::LS_IDLE;
      o_upstream_data_oe <= 1'h0;
    end
    else if (start)
    begin
      st_reg <= tws_pkg::LS_ADDR;
      cnt_reg <= 4'h0;
      o_upstream_data_oe <= 1'h0;
    end
    else
    begin
      case (st_reg)
        tws_pkg::LS_IDLE:
          st_reg <= tws_pkg::LS_IDLE;
        tws_pkg::LS_ADDR, tws_pkg::LS_BYTE:
          if (rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (fall && cnt_reg == 4'h8)
          begin
            cnt_reg <= 4'h0;
            if (st_reg == tws_pkg::LS_BYTE)
            begin
              o_upstream_data_oe <= 1'h1;
              st_reg <= tws_pkg::LS_WACK;
              first_reg <= 1'h0;
              if (first_reg)
                ptr_reg <= shreg;
              else
              begin
                req_word_reg <= '{wr: 1'h1, addr: ptr_reg, data: shreg};
                req_tgl_reg <= ~req_tgl_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
            else if (hit)
            begin
              o_upstream_data_oe <= 1'h1;
              rd_reg <= shreg[0];
              first_reg <= 1'h1;
              st_reg <= tws_pkg::LS_AACK;
              if (shreg[0])
              begin
                req_word_reg <= '{wr: 1'h0, addr: ptr_reg, data: 8'h00};
                req_tgl_reg <= ~req_tgl_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
            else
              st_reg <= tws_pkg::LS_IDLE;
          end
        tws_pkg::LS_AACK:
          if (fall)
          begin
            o_upstream_data_oe <= 1'h0;
            st_reg <= rd_reg ? tws_pkg::LS_RLOAD : tws_pkg::LS_BYTE;
          end
        tws_pkg::LS_WACK:
          if (fall)
          begin
            o_upstream_data_oe <= 1'h0;
            st_reg <= tws_pkg::LS_BYTE;
          end
        tws_pkg::LS_RLOAD:
          if (!busy)
          begin
            shreg <= resp_reg;
            o_upstream_data_oe <= ~resp_reg[7];
            cnt_reg <= 4'h0;
            st_reg <= tws_pkg::LS_RBIT;
          end
        tws_pkg::LS_RBIT:
          if (rise)
            cnt_reg <= cnt_reg + 4'h1;
          else if (fall && cnt_reg == 4'h8)
          begin
            o_upstream_data_oe <= 1'h0;
            st_reg <= tws_pkg::LS_RACK;
          end
          else if (fall)
          begin
            o_upstream_data_oe <= ~shreg[6];
            shreg <= {shreg[6:0], 1'h0};
          end
        tws_pkg::LS_RACK:
          if (rise)
            nack_reg <= sda_s;
          else if (fall && nack_reg)
            st_reg <= tws_pkg::LS_IDLE;
          else if (fall)
          begin
            req_word_reg <= '{wr: 1'h0, addr: ptr_reg, data: 8'h00};
            req_tgl_reg <= ~req_tgl_reg;
            ptr_reg <= ptr_reg + 8'h01;
            st_reg <= tws_pkg::LS_RLOAD;
          end
        default:
          st_reg <= tws_pkg::LS_IDLE;
      endcase
    end
  end

  // clock stretch while a request is in flight
  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_upstream_clock_oe <= 1'h0;
    else
      o_upstream_clock_oe <= acc_s & busy & (o_upstream_clock_oe | ~scl_s);
  end
endmodule
`default_nettype wire

// *** hw/tws_sync.sv ***
// two flip-flop level synchroniser, W bits wide
// inputs are levels that stay stable for at least two destination clocks
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // destination clock
  input wire logic i_rstn, // async reset, active low
  input wire logic [W-1:0] i_d, // foreign levels
  output var logic [W-1:0] o_q // synchronised levels
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_reg <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench for the two-wire bus switch control block
// master model on the upstream lines; checker bound to the top
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"
module tb_top;
  localparam logic [6:0] DA = `TWS_DEV_ADDR;
  localparam logic [6:0] MA = `TWS_MASS_ADDR;
  logic clk, lclk, rstn, en, sup, b1d, b1c, b2d, b2c, f1, f2, cd, cc;
  wire logic scl, sda;
  logic sdo, sdoe, sco, scoe, sw1, sw2, bon, fo, foe, fln, tol, nak;
  logic [15:0] exp_q[$];
  logic [7:0] got, rdv, e, m;
  logic [31:0] r;
  event rd_ev;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int lim;
  int seed = 32'h15e84535;

  initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
  initial begin lclk = 1'b0; #17; forever #40 lclk = ~lclk; end

  tws_switch_ctrl #(.TO_LONG_CYC(40), .TO_MID_CYC(20), .TO_SHORT_CYC(10)) dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_link_clk(lclk), .i_enable(en),
    .i_supply_good(sup), .i_upstream_clock_line(scl), .i_upstream_data_line(sda),
    .i_branch1_data_line(b1d), .i_branch1_clock_line(b1c),
    .i_branch2_data_line(b2d), .i_branch2_clock_line(b2c),
    .i_branch1_fault_in(f1), .i_branch2_fault_in(f2),
    .i_common_data_node(cd), .i_common_clock_node(cc),
    .o_upstream_data_out(sdo), .o_upstream_data_oe(sdoe),
    .o_upstream_clock_out(sco), .o_upstream_clock_oe(scoe),
    .o_branch1_switch_bit(sw1), .o_branch2_switch_bit(sw2), .o_buffers_on(bon),
    .o_fault_out(fo), .o_fault_oe(foe), .o_conn_fail_n(fln), .o_timeout_latched(tol)
  );
  tws_mst u_mst (.i_clk(clk), .i_scl_oe(scoe), .i_sda_oe(sdoe), .o_scl(scl), .o_sda(sda));

  task automatic check(input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    input logic xn);
    u_mst.access(a, 1'b0, p, d, rdv, nak);
    check({7'h00, nak}, {7'h00, xn});
  endtask

  // note the expected value, then read it back
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] me);
    exp_q.push_back(me);
    u_mst.access(DA, 1'b1, p, 8'h00, rdv, nak);
    got = rdv;
    -> rd_ev;
    @(posedge clk);
  endtask

  task automatic pins(input logic [5:0] ex, input logic [5:0] mk);
    @(negedge clk);
    check({sdo | sco, fo, {sw1, sw2, bon, foe, fln, tol} & mk}, {2'h0, ex});
  endtask

  // pull one common node low for n cycles
  task automatic low(input int n);
    r = $random(seed);
    @(posedge clk);
    {cd, cc} <= r[0] ? 2'b01 : 2'b10;
    cyc_n(n);
    {cd, cc} <= 2'b11;
  endtask

  initial
    forever
    begin
      @(rd_ev);
      {m, e} = exp_q.pop_front();
      check(got & m, e);
    end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 125000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    {rstn, en, sup} = 3'b011;
    {b1d, b1c, b2d, b2c, f1, f2, cd, cc} = 8'hFF;
    cyc_n(12);
    rstn <= 1'b1;
    cyc_n(200);
    rd_chk(8'h02, 16'hFF04);
    repeat (2)
    begin
      r = $random(seed);
      @(posedge clk);
      {b1d, b1c, b2d, b2c} <= r[3:0];
      rd_chk(8'h03, {8'hFF, 4'h0, &r[3:2], &r[1:0], 2'h0});
    end
    {b1d, b1c, b2d, b2c} <= 4'hF;
    wr(MA, 8'h02, 8'hFF, 1'b0);
    rd_chk(8'h02, 16'hFF27);
    wr(MA, 8'h02, 8'h00, 1'b0);
    wr(MA, 8'h02, 8'h24, 1'b1);
    rd_chk(8'h02, 16'hFF00);
    @(posedge clk);
    b1c <= 1'b0;
    wr(DA, 8'h03, 8'hC0, 1'b0);
    pins(6'b011100, 6'h3F);
    rd_chk(8'h03, 16'hFB40);
    wr(DA, 8'h00, 8'h00, 1'b0);
    pins(6'b011010, 6'h3F);
    wr(DA, 8'h02, 8'h20, 1'b0);
    wr(DA, 8'h03, 8'hC0, 1'b0);
    pins(6'b111010, 6'h3F);
    for (int k = 1; k < 4; k++)
    begin
      lim = 80 >> k;
      wr(DA, 8'h02, {6'h08, k[1:0]}, 1'b0);
      low(lim - 6);
      cyc_n(4);
      pins(6'h00, 6'h05);
      low(lim - 6);
      cyc_n(4);
      pins(6'h00, 6'h05);
      low(lim + 12);
      pins(6'b110111, 6'h3F);
      wr(DA, 8'h00, 8'h00, 1'b0);
    end
    @(posedge clk);
    en <= 1'b0;
    f1 <= 1'b0;
    cyc_n(20);
    pins(6'b000110, 6'h3F);
    wr(DA, 8'h03, 8'hC0, 1'b1);
    en <= 1'b1;
    cyc_n(200);
    rd_chk(8'h02, 16'hFF04);
    sup <= 1'b0;
    cyc_n(100);
    pins(6'b000010, 6'h3F);
    wr(DA, 8'h03, 8'hC0, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire

// *** tb/tws_chk_asserts.sv ***
// port assertions for the switch control top module
// bound to every instance; system clock domain only
`timescale 1ns/1ps
`default_nettype none
module tws_chk #(
  parameter int unsigned TO_SHORT_CYC = 1
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_enable, // enable pin
  input wire logic i_supply_good, // supply ok
  input wire logic i_branch1_fault_in, // branch 1 fault
  input wire logic i_branch2_fault_in, // branch 2 fault
  input wire logic i_common_data_node, // data node high
  input wire logic i_common_clock_node, // clock node high
  input wire logic o_upstream_data_oe, // data pulled
  input wire logic o_upstream_clock_oe, // clock stretched
  input wire logic o_branch1_switch_bit, // switch 1 closed
  input wire logic o_branch2_switch_bit, // switch 2 closed
  input wire logic o_buffers_on, // buffers biased
  input wire logic o_fault_oe, // fault pulled low
  input wire logic o_conn_fail_n, // refused flag
  input wire logic o_timeout_latched // timeout latched
);
  int unsigned low_cnt;
  int unsigned off_cnt;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn) low_cnt <= 0;
    else if (i_common_data_node && i_common_clock_node) low_cnt <= 0;
    else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn) off_cnt <= 0;
    else if (i_supply_good) off_cnt <= 0;
    else if (off_cnt < 100) off_cnt <= off_cnt + 1;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_fault_fwd: assert property (
    ((!i_branch1_fault_in || !i_branch2_fault_in) && i_supply_good) [*5] |-> o_fault_oe)
    else $error("branch fault not forwarded");
  a_supply_off: assert property (off_cnt >= 80 |->
    !o_fault_oe && !o_upstream_data_oe && !o_upstream_clock_oe)
    else $error("driver active with supply bad");
  a_en_dflt: assert property (!i_enable [*5] |->
    !o_branch1_switch_bit && !o_branch2_switch_bit)
    else $error("switch closed while disabled");
  a_fail_alert: assert property ($fell(o_conn_fail_n) |-> ##[0:3] o_fault_oe)
    else $error("refused connection without fault");
  a_to_iso: assert property ($rose(o_timeout_latched) |->
    ##[0:2] (o_fault_oe && !o_buffers_on))
    else $error("timeout did not isolate");
  a_sw_keep: assert property ($rose(o_timeout_latched) |->
    $stable(o_branch1_switch_bit) && $stable(o_branch2_switch_bit))
    else $error("switches moved on timeout");
  a_iso_hold: assert property (o_timeout_latched [*3] |-> !o_buffers_on)
    else $error("buffers on during timeout");
  a_timer_run: assert property ($rose(o_timeout_latched) |->
    $past(low_cnt, 3) + 2 >= TO_SHORT_CYC)
    else $error("timeout before node low long enough");
endmodule

bind tws_switch_ctrl tws_chk #(.TO_SHORT_CYC(TO_SHORT_CYC)) u_chk (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_enable(i_enable),
  .i_supply_good(i_supply_good),
  .i_branch1_fault_in(i_branch1_fault_in),
  .i_branch2_fault_in(i_branch2_fault_in),
  .i_common_data_node(i_common_data_node),
  .i_common_clock_node(i_common_clock_node),
  .o_upstream_data_oe(o_upstream_data_oe),
  .o_upstream_clock_oe(o_upstream_clock_oe),
  .o_branch1_switch_bit(o_branch1_switch_bit),
  .o_branch2_switch_bit(o_branch2_switch_bit),
  .o_buffers_on(o_buffers_on),
  .o_fault_oe(o_fault_oe),
  .o_conn_fail_n(o_conn_fail_n),
  .o_timeout_latched(o_timeout_latched)
);
`default_nettype wire

// *** tb/tws_mst.sv ***
// upstream two-wire master model for the switch control bench
// lines have pull-ups; each party can only pull low
`timescale 1ns/1ps
`default_nettype none
module tws_mst (
  input wire logic i_clk, // bench system clock
  input wire logic i_scl_oe, // device stretches clock
  input wire logic i_sda_oe, // device pulls data
  output wire logic o_scl, // resolved clock wire
  output wire logic o_sda // resolved data wire
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  assign o_scl = scl_drv & ~i_scl_oe;
  assign o_sda = sda_drv & ~i_sda_oe;

  // three link clocks between line edges; slave reacts within three
  task automatic gap;
    repeat (48) @(posedge i_clk);
  endtask

  // release clock and wait out stretching
  task automatic rise;
    scl_drv <= 1'b1;
    for (int k = 0; k < 4000 && o_scl !== 1'b1; k++) @(posedge i_clk);
    gap();
  endtask

  task automatic bitx(input logic b, output logic r);
    sda_drv <= b;
    gap();
    rise();
    r = o_sda;
    scl_drv <= 1'b0;
    gap();
  endtask

  task automatic start;
    sda_drv <= 1'b1;
    gap();
    rise();
    sda_drv <= 1'b0;
    gap();
    scl_drv <= 1'b0;
    gap();
  endtask

  task automatic stop;
    sda_drv <= 1'b0;
    gap();
    rise();
    sda_drv <= 1'b1;
    gap();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic nk);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, nk);
  endtask

  // read one byte, then nack it
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
  endtask

  task automatic access(input logic [6:0] a, input logic rw, input logic [7:0] p,
    input logic [7:0] wd, output logic [7:0] rd, output logic nk);
    logic n1, n2, n3;
    start();
    wbyte({a, 1'b0}, n1);
    wbyte(p, n2);
    rd = 8'h00;
    if (rw)
    begin
      start();
      wbyte({a, 1'b1}, n3);
      rbyte(rd);
    end
    else
      wbyte(wd, n3);
    stop();
    nk = n1 | n2 | n3;
  endtask
endmodule
`default_nettype wire
